// file: verilog/rsc_engine_node.sv
`timescale 1ns/1ps
module rsc_engine_node #(
    parameter logic [31:0] RETRY_CYCLES      = 32'(rsc_pkg::RETRY_CYC),
    parameter logic [31:0] DATA_DELAY_CYCLES = 32'(rsc_pkg::DATA_DELAY_CYC)
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire rsc_pkg::rsc_pmode_t power_mode,
    input  wire logic               rx_valid,
    input  wire logic [31:0]        rx_header,
    input  wire logic               tx_ready,
    input  wire logic               crank_status_query,
    input  wire logic               fuel_cut_no_restart,
    output logic                    tx_valid,
    output logic [31:0]             tx_header,
    output logic                    crank_request,
    output logic                    remote_run_ok,
    output logic [7:0]              learned_src,
    output logic                    abort_flag,
    output logic                    abort_awaiting_ack,
    output logic                    abort_deadline_miss
);
    import rsc_pkg::*;

    // decode, pending and timer signals
    logic crank_mode_ok;
    logic abort_mode_ok;
    logic even_hdr;
    logic hit_crank_rpt;
    logic hit_abort_ack;
    logic hit_abort_req;
    logic rx_crank_rpt;
    logic rx_abort_ack;
    logic rx_abort_req;
    logic crank_ack_pend_reg;
    logic crank_req_pend_reg;
    logic abort_req_pend_reg;
    logic abort_sent_flag_reg;
    logic abort_change;
    logic launch;
    logic launch_abort;
    logic retry_expired;
    logic retry_pend_reg;
    logic dd_busy;
    logic dd_expired;
    logic [31:0] tx_header_next;

    // power mode windows for each exchange
    assign crank_mode_ok = (power_mode == PM_AWAKE_OFF) ||
                           (power_mode == PM_RUN) ||
                           (power_mode == PM_RETAINED_POWER);
    // abort traffic is limited to awake-off
    assign abort_mode_ok = (power_mode == PM_AWAKE_OFF);

    // header qualification
    assign even_hdr = ~rx_header[HDR_PARITY_BIT];
    assign hit_crank_rpt = (rx_header & HDR_CRANK_RPT_MSK) ==
                           HDR_CRANK_RPT_VAL;
    // abort acknowledge and request match every byte but the source and the top nibble
    assign hit_abort_ack = (rx_header & HDR_EXACT_MSK) == HDR_ABORT_ACK_VAL;
    assign hit_abort_req = (rx_header & HDR_EXACT_MSK) == HDR_ABORT_REQ_VAL;

    // a header counts only when valid, even, matched and in mode
    assign rx_crank_rpt = rx_valid && even_hdr && hit_crank_rpt &&
                          crank_mode_ok;
    assign rx_abort_ack = rx_valid && even_hdr && hit_abort_ack &&
                          abort_mode_ok;
    assign rx_abort_req = rx_valid && even_hdr && hit_abort_req &&
                          abort_mode_ok;

    // received crank flag; acting in one cycle meets the 150 ms bound
    always_ff @(posedge mclk) begin
        if (rst) begin
            crank_request <= CRANK_FLAG_RST;
            remote_run_ok <= CRANK_FLAG_RST;
            learned_src   <= LEARN_SRC_RST;
        end else if (rx_crank_rpt) begin
            crank_request <= rx_header[HDR_FLAG_BIT];
            remote_run_ok <= rx_header[HDR_FLAG_BIT];
            learned_src   <= rx_header[HDR_SRC_LSB +: 8];
        end
    end

    // local abort flag follows the no-restart fuel cut condition
    always_ff @(posedge mclk) begin
        if (rst) begin
            abort_flag <= ABORT_FLAG_RST;
        end else begin
            abort_flag <= fuel_cut_no_restart;
        end
    end

    // a change is pending while the flag differs from the last sent value
    assign abort_change = (abort_flag != abort_sent_flag_reg) &&
                          abort_mode_ok;

    // transmit selection: crank ack first, then abort report, then query
    always_comb begin
        tx_header_next = HDR_CRANK_ACK_TX;
        launch_abort   = 1'b0;
        if (crank_ack_pend_reg) begin
            tx_header_next = HDR_CRANK_ACK_TX;
        end else if (abort_mode_ok && (abort_change || abort_req_pend_reg ||
                     retry_pend_reg)) begin
            tx_header_next = HDR_ABORT_RPT_TX |
                             (32'(abort_flag) << HDR_FLAG_BIT);
            launch_abort   = 1'b1;
        end else begin
            tx_header_next = HDR_CRANK_REQ_TX;
        end
    end

    // load the holding register when it is free or being taken
    assign launch = (~tx_valid || tx_ready) &&
                    (crank_ack_pend_reg || launch_abort ||
                     (crank_req_pend_reg && crank_mode_ok));

    // transmit holding register, held until the link takes it
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_valid  <= 1'b0;
            tx_header <= 32'h00000000;
        end else if (launch) begin
            tx_valid  <= 1'b1;
            tx_header <= tx_header_next;
        end else if (tx_ready) begin
            tx_valid  <= 1'b0;
        end
    end

    // crank acknowledge pending; a new report wins over the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            crank_ack_pend_reg <= 1'b0;
        end else if (rx_crank_rpt) begin
            crank_ack_pend_reg <= 1'b1;
        end else if (launch) begin
            crank_ack_pend_reg <= 1'b0;
        end
    end

    // crank status query from the engine side, only in its modes
    always_ff @(posedge mclk) begin
        if (rst) begin
            crank_req_pend_reg <= 1'b0;
        end else if (crank_status_query && crank_mode_ok) begin
            crank_req_pend_reg <= 1'b1;
        end else if (launch && !crank_ack_pend_reg && !launch_abort) begin
            crank_req_pend_reg <= 1'b0;
        end else if (!crank_mode_ok) begin
            crank_req_pend_reg <= 1'b0;
        end
    end

    // abort status request from the body node
    always_ff @(posedge mclk) begin
        if (rst) begin
            abort_req_pend_reg <= 1'b0;
        end else if (rx_abort_req) begin
            abort_req_pend_reg <= 1'b1;
        end else if ((launch && launch_abort && !crank_ack_pend_reg) ||
                     !abort_mode_ok) begin
            abort_req_pend_reg <= 1'b0;
        end
    end

    // abort report handshake: sent value, wait for ack, retry on timeout
    always_ff @(posedge mclk) begin
        if (rst) begin
            abort_sent_flag_reg <= ABORT_FLAG_RST;
            abort_awaiting_ack  <= 1'b0;
            retry_pend_reg      <= 1'b0;
        end else begin
            if (launch && launch_abort && !crank_ack_pend_reg) begin
                abort_sent_flag_reg <= abort_flag;
                abort_awaiting_ack  <= 1'b1;
                retry_pend_reg      <= 1'b0;
            end else if (rx_abort_ack && !abort_change) begin
                abort_awaiting_ack  <= 1'b0;
                retry_pend_reg      <= 1'b0;
            end else if (retry_expired && abort_awaiting_ack) begin
                retry_pend_reg      <= 1'b1;
            end
        end
    end

    // retry interval between unacknowledged abort reports
    rsc_timer #(
        .W     (TMR_W),
        .COUNT (RETRY_CYCLES)
    ) u_retry (
        .mclk    (mclk),
        .rst     (rst),
        .start   (launch && launch_abort && !crank_ack_pend_reg),
        .stop    (rx_abort_ack),
        .busy    (),
        .expired (retry_expired)
    );

    // data delay watch: flags a flag change not launched within 1 s
    rsc_timer #(
        .W     (TMR_W),
        .COUNT (DATA_DELAY_CYCLES)
    ) u_data_delay (
        .mclk    (mclk),
        .rst     (rst),
        .start   (abort_change && !dd_busy),
        .stop    (!abort_change),
        .busy    (dd_busy),
        .expired (dd_expired)
    );

    // sticky deadline miss indicator, cleared only by reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            abort_deadline_miss <= 1'b0;
        end else if (dd_expired) begin
            abort_deadline_miss <= 1'b1;
        end
    end

endmodule

// file: include/rsc_pkg.sv
package rsc_pkg;

    // power modes reported by the node's own mode manager
    typedef enum logic [2:0] {
        PM_OFF_ASLEEP,
        PM_AWAKE_OFF,
        PM_ACCESSORY,
        PM_RUN,
        PM_CRANK,
        PM_RETAINED_POWER
    } rsc_pmode_t;

    // header patterns: a received header matches when (hdr & mask) == value
    localparam logic [31:0] HDR_CRANK_RPT_VAL = 32'h08870016;
    localparam logic [31:0] HDR_CRANK_RPT_MSK = 32'h0fff007f;
    localparam logic [31:0] HDR_ABORT_ACK_VAL = 32'h09860058;
    localparam logic [31:0] HDR_ABORT_REQ_VAL = 32'h09860018;
    localparam logic [31:0] HDR_EXACT_MSK     = 32'h0fff00ff;

    // transmitted headers
    localparam logic [31:0] HDR_CRANK_ACK_TX  = 32'hc9861056;
    localparam logic [31:0] HDR_CRANK_REQ_TX  = 32'hc9861016;
    localparam logic [31:0] HDR_ABORT_RPT_TX  = 32'ha8871018;

    // field positions
    localparam int HDR_PARITY_BIT = 28;
    localparam int HDR_FLAG_BIT   = 7;
    localparam int HDR_SRC_LSB    = 8;

    // reset values
    localparam logic       CRANK_FLAG_RST = 1'b0;
    localparam logic       ABORT_FLAG_RST = 1'b0;
    localparam logic [7:0] LEARN_SRC_RST  = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACT_DELAY_MS  = 150;
    localparam int DATA_DELAY_MS = 1000;
    localparam int RETRY_MS      = 100;
    localparam int NS_PER_MS     = 1000000;
    localparam int ACT_DELAY_CYC = ACT_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int DATA_DELAY_CYC = DATA_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int RETRY_CYC     = RETRY_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int TMR_W         = 32;

endpackage

// file: verilog/rsc_timer.sv
`timescale 1ns/1ps
module rsc_timer #(
    parameter int          W     = 32,
    parameter logic [31:0] COUNT = 32'h00000010
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic stop,
    output logic      busy,
    output logic      expired
);
    logic [W-1:0] cnt_reg;

    // one-shot down counter; start reloads, stop abandons
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= '0;
            busy    <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                cnt_reg <= W'(COUNT - 32'h1);
                busy    <= 1'b1;
            end else if (stop) begin
                busy <= 1'b0;
            end else if (busy) begin
                if (cnt_reg == '0) begin
                    busy    <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - W'(1);
                end
            end
        end
    end
endmodule

// file: dv/rsc_body_model.sv
`timescale 1ns/1ps
module rsc_body_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_header,
    input  wire logic        ack_en,
    input  wire logic        slow,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [31:0]      rx_header
);
    logic [31:0] q[$];
    logic        remote_locked_reg;

    // queue a header towards the engine node
    task automatic send(input logic [31:0] h);
        q.push_back(h);
    endtask

    // crank report, flag in the top bit of the last byte
    task automatic crank(input logic flag);
        // a locked-out remote start only ever asks for false
        send({24'ha88740, flag && !remote_locked_reg, 7'h16});
    endtask

    // idle link at time zero
    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_header = 32'h0;
    end

    // acks abort reports, drains the queue, scrambles the idle bus
    always @(posedge mclk) begin
        tx_ready <= !slow || !tx_ready;
        // a true abort report ends remote start until ignition cycles
        if (rst)
            remote_locked_reg <= 1'b0;
        else if (tx_valid && tx_ready && tx_header == 32'ha8871098)
            remote_locked_reg <= 1'b1;
        if (ack_en && tx_valid && tx_ready && tx_header[31:8] == 24'ha88710)
            q.push_back(32'hc9864058);
        if (rst || q.size() == 0) begin
            rx_valid <= 1'b0;
            rx_header <= ~rx_header;
        end else begin
            rx_valid <= 1'b1;
            rx_header <= q.pop_front();
        end
    end
endmodule

// file: dv/rsc_engine_node_props.sv
`timescale 1ns/1ps
module rsc_engine_node_props #(
    parameter logic [31:0] RETRY_CYCLES      = 32'h00000014,
    parameter logic [31:0] DATA_DELAY_CYCLES = 32'h00000032
) (
    input wire logic               mclk,
    input wire logic               rst,
    input wire rsc_pkg::rsc_pmode_t power_mode,
    input wire logic               rx_valid,
    input wire logic [31:0]        rx_header,
    input wire logic               tx_ready,
    input wire logic               crank_status_query,
    input wire logic               fuel_cut_no_restart,
    input wire logic               tx_valid,
    input wire logic [31:0]        tx_header,
    input wire logic               crank_request,
    input wire logic               remote_run_ok,
    input wire logic [7:0]         learned_src,
    input wire logic               abort_flag,
    input wire logic               abort_awaiting_ack,
    input wire logic               abort_deadline_miss
);
    import rsc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic crank_ok;
    // modes in which crank reports are taken
    assign crank_ok = power_mode inside {PM_AWAKE_OFF, PM_RUN,
                                         PM_RETAINED_POWER};
    sequence s_crank_rx;
        rx_valid && !rx_header[28] && crank_ok &&
        ((rx_header & HDR_CRANK_RPT_MSK) == HDR_CRANK_RPT_VAL);
    endsequence
    sequence s_ack_tx;
        tx_valid && tx_header == HDR_CRANK_ACK_TX;
    endsequence
    a_crank_flag_follows: assert property (s_crank_rx |=>
        crank_request == $past(rx_header[7]) &&
        learned_src == $past(rx_header[15:8])) else $error("crank flag");
    a_crank_ack_out: assert property (s_crank_rx |-> ##[1:6] s_ack_tx)
        else $error("no crank ack");
    a_odd_nibble_drop: assert property (rx_valid && rx_header[28] |=>
        $stable(crank_request) && $stable(learned_src)) else $error("odd");
    a_mode_gate_rx: assert property (rx_valid && !crank_ok |=>
        $stable(crank_request) && $stable(learned_src)) else $error("mode");
    a_run_ok_twin: assert property (remote_run_ok == crank_request)
        else $error("run ok differs");
    a_abort_follows: assert property (!$past(rst) |->
        abort_flag == $past(fuel_cut_no_restart)) else $error("abort flag");
    a_abort_sent: assert property ($changed(abort_flag) &&
        power_mode == PM_AWAKE_OFF |-> ##[0:8] tx_valid && tx_header ==
        (HDR_ABORT_RPT_TX | (32'(abort_flag) << 7))) else $error("no report");
    a_abort_awake_only: assert property (tx_valid &&
        tx_header[31:8] == 24'ha88710 |-> power_mode == PM_AWAKE_OFF)
        else $error("abort report out of mode");
    a_tx_holds: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_header)) else $error("tx dropped");
    a_deadline_kept: assert property (!abort_deadline_miss)
        else $error("abort deadline missed");
endmodule
bind rsc_engine_node rsc_engine_node_props #(.RETRY_CYCLES(RETRY_CYCLES),
    .DATA_DELAY_CYCLES(DATA_DELAY_CYCLES)) i_props (.*);

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rsc_pkg::*;
    logic        mclk = 1'b0;
    logic        rst;
    rsc_pmode_t  mode;
    logic        query;
    logic        fuel;
    logic        ack_en;
    logic        slow;
    logic        rx_valid, tx_ready, tx_valid, crank, run_ok, abort, wait_ack;
    logic        miss;
    logic [31:0] rx_header, tx_header;
    logic [7:0]  src;
    int          mismatches = 0;
    int          checks_done = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    rsc_engine_node #(.RETRY_CYCLES(32'd20), .DATA_DELAY_CYCLES(32'd50))
    i_rsc_engine_node (.mclk(mclk), .rst(rst), .power_mode(mode),
        .rx_valid(rx_valid), .rx_header(rx_header), .tx_ready(tx_ready),
        .crank_status_query(query), .fuel_cut_no_restart(fuel),
        .tx_valid(tx_valid), .tx_header(tx_header), .crank_request(crank),
        .remote_run_ok(run_ok), .learned_src(src), .abort_flag(abort),
        .abort_awaiting_ack(wait_ack), .abort_deadline_miss(miss));
    rsc_body_model i_rsc_body_model (.mclk(mclk), .rst(rst),
        .tx_valid(tx_valid), .tx_header(tx_header), .ack_en(ack_en),
        .slow(slow), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_header(rx_header));

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // wait, bounded, for the next header taken by the link
    task automatic wait_tx(input logic [31:0] exp);
        int n;
        #1;
        n = 0;
        while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 200) begin
            step(1);
            n++;
        end
        if (n == 200) begin
            $display("BAD %0t no header sent", $time);
            mismatches++;
            final_report;
        end
        chk_w(tx_header, exp);
        step(1);
    endtask

    // watch six cycles for any header offered to the link
    task automatic watch_tx(output logic seen);
        seen = 1'b0;
        repeat (6) begin
            step(1);
            if (tx_valid !== 1'b0) seen = 1'b1;
        end
    endtask

    task automatic t_crank_modes;
        logic ok;
        for (int m = 0; m < 6; m++) begin
            @(posedge mclk);
            mode <= rsc_pmode_t'(m);
            ok = (m == 1 || m == 3 || m == 5);
            step(1);
            i_rsc_body_model.crank(1'b1);
            step(2);
            chk_b(crank, ok);
            if (ok) wait_tx(HDR_CRANK_ACK_TX);
            i_rsc_body_model.crank(1'b0);
            step(2);
            chk_b(crank, 1'b0);
            if (ok) wait_tx(HDR_CRANK_ACK_TX);
        end
    endtask

    task automatic t_crank_edge;
        i_rsc_body_model.send(32'h98874096);
        step(2);
        chk_b(crank, 1'b0);
        i_rsc_body_model.send(32'h28871596);
        step(2);
        chk_w({23'h0, run_ok, src}, 32'h115);
        wait_tx(HDR_CRANK_ACK_TX);
    endtask

    task automatic t_query;
        logic seen;
        @(posedge mclk);
        slow <= 1'b1;
        query <= 1'b1;
        @(posedge mclk);
        query <= 1'b0;
        wait_tx(HDR_CRANK_REQ_TX);
        @(posedge mclk);
        mode <= PM_ACCESSORY;
        query <= 1'b1;
        @(posedge mclk);
        query <= 1'b0;
        watch_tx(seen);
        chk_b(seen, 1'b0);
    endtask

    task automatic t_abort;
        logic seen;
        @(posedge mclk);
        slow <= 1'b0;
        mode <= PM_AWAKE_OFF;
        ack_en <= 1'b1;
        fuel <= 1'b1;
        wait_tx(32'ha8871098);
        chk_b(abort, 1'b1);
        step(4);
        chk_b(wait_ack, 1'b0);
        @(posedge mclk);
        ack_en <= 1'b0;
        fuel <= 1'b0;
        wait_tx(32'ha8871018);
        wait_tx(32'ha8871018);
        i_rsc_body_model.send(32'hc9864058);
        step(4);
        chk_b(wait_ack, 1'b0);
        i_rsc_body_model.send(32'hc9864018);
        wait_tx(32'ha8871018);
        @(posedge mclk);
        mode <= PM_RUN;
        step(1);
        i_rsc_body_model.send(32'hc9864058);
        step(4);
        chk_b(wait_ack, 1'b1);
        chk_b(miss, 1'b0);
        i_rsc_body_model.send(32'hc9864018);
        watch_tx(seen);
        chk_b(seen, 1'b0);
        i_rsc_body_model.crank(1'b1);
        step(2);
        chk_b(crank, 1'b0);
    endtask

    // reset, then the scenarios in turn
    initial begin
        rst    <= 1'b1;
        mode   <= PM_RUN;
        query  <= 1'b0;
        fuel   <= 1'b0;
        ack_en <= 1'b0;
        slow   <= 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        step(1);
        chk_w(32'({crank, run_ok, abort, wait_ack, tx_valid, src}), 0);
        t_crank_modes;
        t_crank_edge;
        t_query;
        t_abort;
        final_report;
    end
endmodule
